// ---- src/qasc_cfg.svh ----
// Constants for the quad converter scan controller
`ifndef QASC_CFG_SVH
`define QASC_CFG_SVH

// ----------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------
`define QASC_NCONV              4
`define QASC_CMD_W              8
`define QASC_SMP_W              16
`define QASC_SHIFT_BITS         5'd16
`define QASC_BUF_DEPTH          2

// ----------------------------------------------------------------
// Byte offsets of the register set
// ----------------------------------------------------------------
`define QASC_OFFS_SAMPLE_ZERO   8'h00
`define QASC_OFFS_SAMPLE_ONE    8'h02
`define QASC_OFFS_SAMPLE_TWO    8'h04
`define QASC_OFFS_SAMPLE_THREE  8'h06
`define QASC_OFFS_COMMAND_ZERO  8'h00
`define QASC_OFFS_CMD_WORD      8'h08
`define QASC_OFFS_COMMAND_ONE   8'h09
`define QASC_OFFS_COMMAND_TWO   8'h0a
`define QASC_OFFS_COMMAND_THREE 8'h0b

// ----------------------------------------------------------------
// Command byte fields and reset value
// ----------------------------------------------------------------
`define QASC_CMD_SINGLE_ENDED_FLAG  7
`define QASC_CMD_ODD_SIGN           6
`define QASC_CMD_SEL_HI             5
`define QASC_CMD_SEL_LO             4
`define QASC_CMD_RANGE_POLARITY_BIT 3
`define QASC_CMD_GAIN               2
`define QASC_CMD_RESET              8'h80

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define QASC_CLK_MHZ            200
`define QASC_CONV_PULSE_NS      40
`define QASC_CONV_WAIT_NS       4000
`define QASC_CONV_PULSE_CYC     ((`QASC_CONV_PULSE_NS * `QASC_CLK_MHZ + 999) / 1000)
`define QASC_CONV_WAIT_CYC      ((`QASC_CONV_WAIT_NS * `QASC_CLK_MHZ + 999) / 1000)

`endif

// ---- src/qasc_pkg.sv ----
// Types for the quad converter scan controller
package qasc_pkg;

	// Scan engine states
	typedef enum logic [1:0] {
		ST_CONV,
		ST_WAIT,
		ST_SHIFT,
		ST_PUSH
	} qasc_state_t;

endpackage

// ---- src/qasc_buf.sv ----
// Two-entry valid/ready buffer between scan engine and result registers
`timescale 1ns/1ps

module qasc_buf #(
	parameter int W     = 64,
	parameter int DEPTH = 2
) (
	input  wire logic         CLK,
	input  wire logic         SYS_RST,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);

	localparam int PW = $clog2(DEPTH);

	logic [W-1:0] mem_q [DEPTH];
	logic [PW-1:0] wr_q;
	logic [PW-1:0] rd_q;
	logic [PW:0]   cnt_q;
	logic          push;
	logic          pop;

	// ----------------------------------------------------------------
	// Handshakes
	// ----------------------------------------------------------------
	assign in_ready  = (cnt_q != (PW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem_q[rd_q];

	// Storage, written only on an accepted push
	always_ff @(posedge CLK) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	// Pointers wrap at the depth
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == PW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == PW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
			end
		end
	end

	// Fill level, gives honest full and empty
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			cnt_q <= '0;
		end else if (push && !pop) begin
			cnt_q <= cnt_q + 1'b1;
		end else if (pop && !push) begin
			cnt_q <= cnt_q - 1'b1;
		end
	end

endmodule

// ---- src/qasc_top.sv ----
// Quad converter scan controller: command registers, serial scan engine, result registers
//
// Overview of operation
// - Drive four converters, eight-way muxed each
// - One command byte configures each converter
// - Command bytes writable at 0x08, 0x09, 0x0a, 0x0b; converter zero's also at 0x00
// - Scan from reset, no trigger; pause only while the buffer is full
// - Latest samples readable at 0x00..0x06
// - Results are sixteen bits wide
// - Command sent MSB first, zeros trail
// - Everything reached through memory-mapped registers
// - Results are unmodified natural binary codes
`timescale 1ns/1ps
`include "qasc_cfg.svh"

module qasc_top (
	input  wire logic        CLK,
	input  wire logic        SYS_RST,
	input  wire logic [7:0]  REG_ADDR,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	input  wire logic [3:0]  REG_BE,
	input  wire logic [31:0] REG_WDATA,
	output logic [31:0]      REG_RDATA,
	input  wire logic        ADC_SCK,
	input  wire logic [3:0]  ADC_SDO,
	output logic             ADC_CONV,
	output logic [3:0]       ADC_SDI
);

	localparam int NC = `QASC_NCONV;
	localparam int SW = `QASC_SMP_W;
	localparam int CW = `QASC_CMD_W;

	qasc_pkg::qasc_state_t state_q;
	logic [11:0]       cnt_q;
	logic [4:0]        bit_q;
	logic              sck_m_q;
	logic              sck_s_q;
	logic              sck_p_q;
	logic [NC-1:0]     sdo_m_q;
	logic [NC-1:0]     sdo_s_q;
	logic              sck_rise;
	logic              sck_fall;
	logic              conv_done;
	logic              wait_done;
	logic              shift_done;
	logic [5:0]        word;
	logic [CW-1:0]     cmd_q   [NC];
	logic [CW-1:0]     sdi_sr_q [NC];
	logic [SW-1:0]     sdo_sr_q [NC];
	logic [SW-1:0]     res_q   [NC];
	logic [NC*SW-1:0]  push_data;
	logic [NC*SW-1:0]  pop_data;
	logic              push_valid;
	logic              push_ready;
	logic              pop_valid;
	logic              pop_ready;

	// ----------------------------------------------------------------
	// Link input synchronisers
	// ----------------------------------------------------------------
	// Two stages before any edge detection; third stage only for the edge
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			sck_m_q <= 1'b0;
			sck_s_q <= 1'b0;
			sck_p_q <= 1'b0;
			sdo_m_q <= '0;
			sdo_s_q <= '0;
		end else begin
			sck_m_q <= ADC_SCK;
			sck_s_q <= sck_m_q;
			sck_p_q <= sck_s_q;
			sdo_m_q <= ADC_SDO;
			sdo_s_q <= sdo_m_q;
		end
	end

	assign sck_rise   = sck_s_q && !sck_p_q;
	assign sck_fall   = !sck_s_q && sck_p_q;
	assign conv_done  = (state_q == qasc_pkg::ST_CONV) && (cnt_q == 12'(`QASC_CONV_PULSE_CYC - 1));
	assign wait_done  = (state_q == qasc_pkg::ST_WAIT) && (cnt_q == 12'(`QASC_CONV_WAIT_CYC - 1));
	assign shift_done = (state_q == qasc_pkg::ST_SHIFT) && sck_rise && (bit_q == `QASC_SHIFT_BITS - 5'd1);

	// ----------------------------------------------------------------
	// Scan sequencer
	// ----------------------------------------------------------------
	// Starts straight out of reset, stops only in ST_PUSH while the buffer is full; no host trigger exists
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			state_q  <= qasc_pkg::ST_CONV;
			cnt_q    <= '0;
			ADC_CONV <= 1'b1;
		end else begin
			case (state_q)
				qasc_pkg::ST_CONV: begin
					cnt_q <= cnt_q + 12'h001;
					if (conv_done) begin
						state_q  <= qasc_pkg::ST_WAIT;
						cnt_q    <= '0;
						ADC_CONV <= 1'b0;
					end
				end
				qasc_pkg::ST_WAIT: begin
					cnt_q <= cnt_q + 12'h001;
					if (wait_done) begin
						state_q <= qasc_pkg::ST_SHIFT;
						cnt_q   <= '0;
					end
				end
				qasc_pkg::ST_SHIFT: begin
					if (shift_done) begin
						state_q <= qasc_pkg::ST_PUSH;
					end
				end
				default: begin
					// Stalls here while the buffer is full, so no frame is lost
					if (push_ready) begin
						state_q  <= qasc_pkg::ST_CONV;
						ADC_CONV <= 1'b1;
					end
				end
			endcase
		end
	end

	// Clock edges seen during the frame
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			bit_q <= '0;
		end else if (state_q != qasc_pkg::ST_SHIFT) begin
			bit_q <= '0;
		end else if (sck_rise) begin
			bit_q <= bit_q + 5'd1;
		end
	end

	// ----------------------------------------------------------------
	// Per-converter command, shift and result logic
	// ----------------------------------------------------------------
	assign word = REG_ADDR[7:2];

	for (genvar i = 0; i < NC; i++) begin : g_conv
		// Command byte: lane i of the command word, converter_zero also lane 0 of word 0
		always_ff @(posedge CLK or posedge SYS_RST) begin
			if (SYS_RST) begin
				cmd_q[i] <= `QASC_CMD_RESET;
			end else if (REG_WR && REG_BE[i] && (word == 6'(`QASC_OFFS_CMD_WORD >> 2))) begin
				cmd_q[i] <= REG_WDATA[i*8 +: 8];
			end else if (i == 0 && REG_WR && REG_BE[0] && (word == 6'(`QASC_OFFS_COMMAND_ZERO >> 2))) begin
				cmd_q[i] <= REG_WDATA[7:0];
			end
		end

		// Command snapshot on wait_done, as the shift starts; a write during the shift waits for the next frame
		always_ff @(posedge CLK or posedge SYS_RST) begin
			if (SYS_RST) begin
				sdi_sr_q[i] <= '0;
				ADC_SDI[i]  <= 1'b0;
			end else if (wait_done) begin
				ADC_SDI[i]  <= cmd_q[i][`QASC_CMD_SINGLE_ENDED_FLAG];
				sdi_sr_q[i] <= {cmd_q[i][CW-2:0], 1'b0};
			end else if (state_q == qasc_pkg::ST_SHIFT && sck_fall && bit_q != 5'd0) begin
				// Zeros trail once the byte is out
				ADC_SDI[i]  <= sdi_sr_q[i][CW-1];
				sdi_sr_q[i] <= {sdi_sr_q[i][CW-2:0], 1'b0};
			end else if (state_q != qasc_pkg::ST_SHIFT) begin
				ADC_SDI[i] <= 1'b0;
			end
		end

		// Sample arrives MSB first on each rising link clock edge
		always_ff @(posedge CLK or posedge SYS_RST) begin
			if (SYS_RST) begin
				sdo_sr_q[i] <= '0;
			end else if (state_q == qasc_pkg::ST_SHIFT && sck_rise) begin
				sdo_sr_q[i] <= {sdo_sr_q[i][SW-2:0], sdo_s_q[i]};
			end
		end

		assign push_data[i*SW +: SW] = sdo_sr_q[i];

		// Result register loads whole words only, straight from the buffer
		always_ff @(posedge CLK or posedge SYS_RST) begin
			if (SYS_RST) begin
				res_q[i] <= '0;
			end else if (pop_valid && pop_ready) begin
				res_q[i] <= pop_data[i*SW +: SW];
			end
		end
	end

	// ----------------------------------------------------------------
	// Frame buffer
	// ----------------------------------------------------------------
	assign push_valid = (state_q == qasc_pkg::ST_PUSH);
	// Results hold still during a read so a word never tears
	assign pop_ready  = !REG_RD;

	qasc_buf #(
		.W     (NC*SW),
		.DEPTH (`QASC_BUF_DEPTH)
	) u_buf (
		.CLK       (CLK),
		.SYS_RST   (SYS_RST),
		.in_valid  (push_valid),
		.in_ready  (push_ready),
		.in_data   (push_data),
		.out_valid (pop_valid),
		.out_ready (pop_ready),
		.out_data  (pop_data)
	);

	// ----------------------------------------------------------------
	// Register read port
	// ----------------------------------------------------------------
	// One cycle latency; unmapped words and idle cycles read zero
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			REG_RDATA <= '0;
		end else if (!REG_RD) begin
			REG_RDATA <= '0;
		end else if (word == 6'(`QASC_OFFS_SAMPLE_ZERO >> 2)) begin
			REG_RDATA <= {res_q[1], res_q[0]};
		end else if (word == 6'(`QASC_OFFS_SAMPLE_TWO >> 2)) begin
			REG_RDATA <= {res_q[3], res_q[2]};
		end else if (word == 6'(`QASC_OFFS_CMD_WORD >> 2)) begin
			REG_RDATA <= {cmd_q[3], cmd_q[2], cmd_q[1], cmd_q[0]};
		end else begin
			REG_RDATA <= '0;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST);

	a_conv_pulse_len: assert property ($rose(ADC_CONV) |-> ADC_CONV[*8] ##1 !ADC_CONV)
		else $error("convert pulse length wrong");
	a_loop_restart: assert property (state_q == qasc_pkg::ST_PUSH && push_ready |=> $rose(ADC_CONV))
		else $error("scan did not restart after push");
	a_frame_bits: assert property ($rose(state_q == qasc_pkg::ST_PUSH) |-> $past(bit_q) == 5'd15)
		else $error("frame not sixteen edges");
	// Compare against the snapshot edge, a write in that same cycle must not count
	a_sdi_first_bit: assert property (wait_done |=>
		ADC_SDI == $past({cmd_q[3][7], cmd_q[2][7], cmd_q[1][7], cmd_q[0][7]}))
		else $error("first command bit wrong");
	a_sdi_zero_tail: assert property (state_q == qasc_pkg::ST_SHIFT && bit_q > 5'd8 |-> ADC_SDI == 4'h0)
		else $error("trailing bits not zero");
	a_cmd_lane_write: assert property (REG_WR && REG_BE[1] && word == 6'h02 |=> cmd_q[1] == $past(REG_WDATA[15:8]))
		else $error("command byte not written");
	a_sample_read: assert property (REG_RD && word == 6'h00 |=> REG_RDATA == {res_q[1], res_q[0]})
		else $error("sample read mismatch");
	a_no_tear: assert property (REG_RD |=> $stable(res_q[0]) && $stable(res_q[3]))
		else $error("result changed under read");
	a_result_load: assert property (pop_valid && pop_ready |=> res_q[2] == $past(pop_data[47:32]))
		else $error("result not loaded from buffer");

	c_frame_pushed: cover property (state_q == qasc_pkg::ST_PUSH && push_ready);
	c_push_stalled: cover property (state_q == qasc_pkg::ST_PUSH && !push_ready);
	c_read_stall:   cover property (pop_valid && REG_RD);
	c_cmd_word:     cover property (REG_WR && REG_BE == 4'hf && word == 6'h02);

endmodule

// ---- verif/qasc_adc_model.sv ----
// Behavioural model of the four serial converters on the scan link
`timescale 1ns/1ps

module qasc_adc_model (
	input  wire logic       ADC_CONV,
	input  wire logic [3:0] ADC_SDI,
	output logic            ADC_SCK,
	output logic [3:0]      ADC_SDO
);
	// ----------------------------------------------------------------
	// Per-converter state, four converters with eight-way inputs
	// ----------------------------------------------------------------
	logic [15:0] rx_q [4];
	logic [15:0] tx_q [4];

	// One frame per falling convert strobe; the clock stands still between frames
	initial begin
		ADC_SCK = 1'b0;
		ADC_SDO = 4'h0;
		for (int i = 0; i < 4; i++) rx_q[i] = 16'h0000;
		forever begin
			@(negedge ADC_CONV);
			// Result echoes last frame's command so the command path is visible
			for (int i = 0; i < 4; i++) tx_q[i] = {rx_q[i][15:8], ~rx_q[i][7:0]};
			#4100;
			for (int b = 15; b >= 0; b--) begin
				for (int i = 0; i < 4; i++) ADC_SDO[i] = tx_q[i][b];
				#24 ADC_SCK = 1'b1;
				// Command enters MSB first, trailing bits must be zero
				for (int i = 0; i < 4; i++) rx_q[i][b] = ADC_SDI[i];
				#24 ADC_SCK = 1'b0;
			end
			// Released line: no pull, so show the inverse of the last bit
			ADC_SDO = ~ADC_SDO;
		end
	end
endmodule

// ---- verif/testbench.sv ----
// Self-checking bench for the quad converter scan controller
`timescale 1ns/1ps

module testbench;
	logic        clk;
	logic        sys_rst;
	logic [7:0]  reg_addr;
	logic        reg_wr;
	logic        reg_rd;
	logic [3:0]  reg_be;
	logic [31:0] reg_wdata;
	logic [31:0] reg_rdata;
	logic        adc_sck;
	logic [3:0]  adc_sdo;
	logic        adc_conv;
	logic [3:0]  adc_sdi;
	int          error_cnt;
	int          total_checks;
	int          cyc;

	// ----------------------------------------------------------------
	// Design and converter model
	// ----------------------------------------------------------------
	qasc_top u_dut (
		.CLK       (clk),
		.SYS_RST   (sys_rst),
		.REG_ADDR  (reg_addr),
		.REG_WR    (reg_wr),
		.REG_RD    (reg_rd),
		.REG_BE    (reg_be),
		.REG_WDATA (reg_wdata),
		.REG_RDATA (reg_rdata),
		.ADC_SCK   (adc_sck),
		.ADC_SDO   (adc_sdo),
		.ADC_CONV  (adc_conv),
		.ADC_SDI   (adc_sdi)
	);

	qasc_adc_model u_adc (
		.ADC_CONV (adc_conv),
		.ADC_SDI  (adc_sdi),
		.ADC_SCK  (adc_sck),
		.ADC_SDO  (adc_sdo)
	);

	// ----------------------------------------------------------------
	// Clock and hang guard
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// About fifteen frames are expected; twice that means a hang
	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			error_cnt++;
			summarize();
		end
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic reg_write(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
		@(posedge clk);
		#1;
		reg_addr = a;
		reg_be = be;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge clk);
		#1;
		reg_wr = 1'b0;
	endtask

	// Read data stands for the one cycle after the strobe edge
	task automatic read_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		#1;
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge clk);
		#1;
		reg_rd = 1'b0;
		check(name, reg_rdata, exp);
	endtask

	// Results land a few cycles after the next strobe rises
	task automatic wait_frames(input int n);
		repeat (n) @(posedge adc_conv);
		repeat (4) @(posedge clk);
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		sys_rst = 1'b1;
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_be = 4'h0;
		reg_wdata = 32'h00000000;
		repeat (12) @(posedge clk);
		#1;
		check("conv in reset", {31'h0, adc_conv}, 32'h1);
		check("sdi in reset", {28'h0, adc_sdi}, 32'h0);
		check("rdata in reset", reg_rdata, 32'h0);
		sys_rst = 1'b0;

		// Scanning starts untriggered with the reset commands
		read_chk("reset cmds", 8'h08, 32'h80808080);
		@(posedge clk);
		#1;
		check("rdata idle", reg_rdata, 32'h0);
		wait_frames(1);
		read_chk("first frame", 8'h00, 32'h00ff00ff);
		wait_frames(1);
		read_chk("word0 reset", 8'h00, 32'h80ff80ff);
		read_chk("word1 reset", 8'h04, 32'h80ff80ff);
		$display("test reset_scan done");

		// Whole-word command write, then one byte lane at 0x0a
		reg_write(8'h08, 4'hf, 32'h9404b810);
		reg_write(8'h0a, 4'h4, 32'h008c0000);
		read_chk("cmd word", 8'h08, 32'h948cb810);
		wait_frames(3);
		read_chk("word0 cmds", 8'h00, 32'hb8ff10ff);
		read_chk("word1 cmds", 8'h04, 32'h94ff8cff);
		$display("test commands done");

		// Sample words (0x00 also takes converter zero's command) and unmapped places
		reg_write(8'h00, 4'hf, 32'h12345644);
		reg_write(8'h04, 4'hf, 32'hdeadbeef);
		read_chk("cmd after ro", 8'h08, 32'h948cb844);
		read_chk("unmapped 0c", 8'h0c, 32'h0);
		read_chk("unmapped fc", 8'hfc, 32'h0);
		wait_frames(3);
		read_chk("word0 ro", 8'h00, 32'hb8ff44ff);
		read_chk("word1 ro", 8'h04, 32'h94ff8cff);
		$display("test read_only done");

		// Reads every cycle hold off every pop, so the value must not move at all
		reg_write(8'h08, 4'h1, 32'h00000020);
		@(posedge clk);
		#1;
		reg_addr = 8'h00;
		reg_rd = 1'b1;
		repeat (4000) begin
			@(posedge clk);
			#1;
			check("held read", reg_rdata, 32'hb8ff44ff);
		end
		check("conv stalled", {31'h0, adc_conv}, 32'h0);
		reg_rd = 1'b0;
		wait_frames(3);
		read_chk("after stall", 8'h00, 32'hb8ff20ff);
		$display("test stall done");
		summarize();
	end
endmodule
